/* File: include/operand_fmt_regs.vh */
// Purpose: constants for the operand half-word formatter
// Assumes: 30-bit words split into two 15-bit halves
// Notes:   register map, field positions and mode codes
`ifndef OPERAND_FMT_REGS_VH
`define OPERAND_FMT_REGS_VH

`define WORD_W          30
`define HALF_W          15
`define HALF_LO_MSB     14
`define HALF_HI_LSB     15
`define HALF_HI_MSB     29

// read modes
`define MODE_LOWER      3'h0
`define MODE_UPPER      3'h1
`define MODE_WHOLE      3'h2
`define MODE_LOWER_SX   3'h3
`define MODE_UPPER_SX   3'h4
`define MODE_IMM        3'h5
`define MODE_IMM_SX     3'h6

// operand sources
`define SRC_MEM         2'h0
`define SRC_ACC         2'h1
`define SRC_INDEX       2'h2
`define SRC_IMM         2'h3

// store modes
`define ST_LOWER        2'h0
`define ST_UPPER        2'h1
`define ST_WHOLE        2'h2

// register offsets (byte addresses)
`define REG_CTRL        6'h00
`define REG_INSTR       6'h04
`define REG_BASE        6'h08
`define REG_ACC         6'h0c
`define REG_MEMDATA     6'h10
`define REG_RESULT      6'h14
`define REG_ADDR        6'h18
`define REG_STORE       6'h1c
`define REG_INDEX0      6'h20
`define ADDR_W          6

// control register fields
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_SRC_LSB    4
`define CTRL_SRC_MSB    5
`define CTRL_IDX_LSB    8
`define CTRL_IDX_MSB    10
`define CTRL_INCR_LSB   16
`define CTRL_ST_LSB     12
`define CTRL_ST_MSB     13
`define CTRL_IDXONLY    14
`define CTRL_INCR_W     16

`define NUM_INDEX       8
`define IDX_NONE        3'h0

`endif

/* File: core/read_formatter.v */
// Purpose: shape a 30-bit operand into the arithmetic register image
// Assumes: mode codes from the constants header
// Notes:   purely combinational, one clock of slack
`timescale 1ns/1ps
`default_nettype none
`include "operand_fmt_regs.vh"
module read_formatter (
  input  wire [2:0]            mode_i,
  input  wire [`WORD_W-1:0]    word_i,
  output reg  [`WORD_W-1:0]    fmt_o
);
  wire [`HALF_W-1:0] lo_half;
  wire [`HALF_W-1:0] hi_half;
  assign lo_half = word_i[`HALF_LO_MSB:0];
  assign hi_half = word_i[`HALF_HI_MSB:`HALF_HI_LSB];

  // all paths settle in one cycle
  always @* begin
    case (mode_i)
      `MODE_LOWER:    fmt_o = {{`HALF_W{1'b0}}, lo_half};
      `MODE_UPPER:    fmt_o = {{`HALF_W{1'b0}}, hi_half};
      `MODE_WHOLE:    fmt_o = word_i;
      `MODE_LOWER_SX: fmt_o = {{`HALF_W{lo_half[`HALF_W-1]}}, lo_half};
      `MODE_UPPER_SX: fmt_o = {{`HALF_W{hi_half[`HALF_W-1]}}, hi_half};
      `MODE_IMM:      fmt_o = {{`HALF_W{1'b0}}, lo_half};
      `MODE_IMM_SX:   fmt_o = {{`HALF_W{lo_half[`HALF_W-1]}}, lo_half};
      default:        fmt_o = word_i;
    endcase
  end
endmodule
`default_nettype wire

/* File: core/store_merger.v */
// Purpose: merge a register value into a destination word
// Assumes: store mode codes from the constants header
// Notes:   untouched half of the destination is kept
`timescale 1ns/1ps
`default_nettype none
`include "operand_fmt_regs.vh"
module store_merger (
  input  wire [1:0]            mode_i,
  input  wire [`WORD_W-1:0]    src_i,
  input  wire [`WORD_W-1:0]    dest_i,
  output reg  [`WORD_W-1:0]    merged_o
);
  always @* begin
    case (mode_i)
      `ST_LOWER: merged_o = {dest_i[`HALF_HI_MSB:`HALF_HI_LSB],
                             src_i[`HALF_LO_MSB:0]};
      `ST_UPPER: merged_o = {src_i[`HALF_LO_MSB:0], dest_i[`HALF_LO_MSB:0]};
      `ST_WHOLE: merged_o = src_i;
      default:   merged_o = src_i;
    endcase
  end
endmodule
`default_nettype wire

/* File: core/operand_half_word_formatter.v */
// Purpose: operand formatting and address path with a Wishbone slave
// Assumes: classic Wishbone, 32-bit data, single clock, sync reset
// Notes:   ack one cycle after stb; results registered on every clock
`timescale 1ns/1ps
`default_nettype none
`include "operand_fmt_regs.vh"
module operand_half_word_formatter (
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  cyc_i,
  input  wire                  stb_i,
  input  wire                  we_i,
  input  wire [`ADDR_W-1:0]    adr_i,
  input  wire [3:0]            sel_i,
  input  wire [31:0]           dat_i,
  output reg  [31:0]           dat_o,
  output reg                   ack_o,
  output reg  [`HALF_W-1:0]    mem_addr_o,
  output reg  [`WORD_W-1:0]    result_o,
  output reg  [`WORD_W-1:0]    store_word_o
);

////////////////////////////////////////////////////////////////////////////////
// software-visible state

  reg [31:0]          ctrl_r;
  reg [`WORD_W-1:0]   instr_r;
  reg [`HALF_W-1:0]   base_r;
  reg [`WORD_W-1:0]   acc_r;
  reg [`WORD_W-1:0]   memdata_r;
  reg [`HALF_W-1:0]   index_r [1:`NUM_INDEX-1];

  wire [2:0]  mode     = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire [1:0]  src      = ctrl_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  wire [2:0]  idx_sel  = ctrl_r[`CTRL_IDX_MSB:`CTRL_IDX_LSB];
  wire [1:0]  st_mode  = ctrl_r[`CTRL_ST_MSB:`CTRL_ST_LSB];
  wire        idx_only = ctrl_r[`CTRL_IDXONLY];
  wire [`CTRL_INCR_W-1:0] incr = ctrl_r[31:`CTRL_INCR_LSB];

////////////////////////////////////////////////////////////////////////////////
// helpers

  // index zero reads as nothing added
  function [`HALF_W-1:0] index_value;
    input [2:0] sel;
    begin
      if (sel == `IDX_NONE)
        index_value = {`HALF_W{1'b0}};
      else
        index_value = index_r[sel];
    end
  endfunction

  function [31:0] pad_word;
    input [`WORD_W-1:0] w;
    begin
      pad_word = {2'h0, w};
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// address generation

  // the array is read directly so that a write to the selected index
  // register re-evaluates this path; a function call would only wake on
  // its argument
  reg  [`HALF_W-1:0] idx_val;
  always @* begin
    if (idx_sel == `IDX_NONE)
      idx_val = {`HALF_W{1'b0}};
    else
      idx_val = index_r[idx_sel];
  end
  // increment wraps modulo the 15-bit address space, as a signed offset
  wire [`HALF_W-1:0] base_incr = base_r + incr[`HALF_W-1:0];
  wire [`HALF_W-1:0] eff_addr  = idx_only ? idx_val
                                          : base_incr + idx_val;
  // modified instruction: index summed into the low field
  wire [`HALF_W-1:0] instr_lo  = instr_r[`HALF_LO_MSB:0] + idx_val;
  wire [`WORD_W-1:0] instr_mod = {instr_r[`HALF_HI_MSB:`HALF_HI_LSB], instr_lo};

////////////////////////////////////////////////////////////////////////////////
// operand selection and formatting

  reg  [`WORD_W-1:0] src_word;
  reg  [2:0]         eff_mode;
  always @* begin
    eff_mode = mode;
    case (src)
      `SRC_MEM:   src_word = memdata_r;
      `SRC_ACC: begin
        src_word = acc_r;
        eff_mode = `MODE_WHOLE;
      end
      `SRC_INDEX: src_word = {{`HALF_W{1'b0}}, idx_val};
      `SRC_IMM:   src_word = {{`HALF_W{1'b0}}, instr_r[`HALF_LO_MSB:0]};
      default:    src_word = memdata_r;
    endcase
  end

  wire [`WORD_W-1:0] fmt_word;
  read_formatter u_read (
    .mode_i (eff_mode),
    .word_i (src_word),
    .fmt_o  (fmt_word)
  );

  wire [`WORD_W-1:0] merged_word;
  store_merger u_store (
    .mode_i   (st_mode),
    .src_i    (acc_r),
    .dest_i   (memdata_r),
    .merged_o (merged_word)
  );

////////////////////////////////////////////////////////////////////////////////
// wishbone slave

  wire req    = cyc_i & stb_i & ~ack_o;
  wire wr_req = req & we_i;
  wire full_w = &sel_i;

  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o        <= 1'b0;
      dat_o        <= 32'h0;
      ctrl_r       <= 32'h0;
      instr_r      <= {`WORD_W{1'b0}};
      base_r       <= {`HALF_W{1'b0}};
      acc_r        <= {`WORD_W{1'b0}};
      memdata_r    <= {`WORD_W{1'b0}};
      mem_addr_o   <= {`HALF_W{1'b0}};
      result_o     <= {`WORD_W{1'b0}};
      store_word_o <= {`WORD_W{1'b0}};
      for (i = 1; i < `NUM_INDEX; i = i + 1) begin
        index_r[i] <= {`HALF_W{1'b0}};
      end
    end else begin
      ack_o <= req;
      // the formatted outputs track the state every cycle
      mem_addr_o   <= eff_addr;
      result_o     <= fmt_word;
      store_word_o <= merged_word;
      if (wr_req && full_w) begin
        case (adr_i)
          `REG_CTRL:    ctrl_r    <= dat_i;
          `REG_INSTR:   instr_r   <= dat_i[`WORD_W-1:0];
          `REG_BASE:    base_r    <= dat_i[`HALF_W-1:0];
          `REG_ACC:     acc_r     <= dat_i[`WORD_W-1:0];
          `REG_MEMDATA: memdata_r <= dat_i[`WORD_W-1:0];
          default: begin
            if (adr_i[`ADDR_W-1] && adr_i[4:2] != `IDX_NONE)
              index_r[adr_i[4:2]] <= dat_i[`HALF_W-1:0];
          end
        endcase
      end
      if (req && !we_i) begin
        case (adr_i)
          `REG_CTRL:    dat_o <= ctrl_r;
          `REG_INSTR:   dat_o <= pad_word(instr_mod);
          `REG_BASE:    dat_o <= {17'h0, base_r};
          `REG_ACC:     dat_o <= pad_word(acc_r);
          `REG_MEMDATA: dat_o <= pad_word(memdata_r);
          `REG_RESULT:  dat_o <= pad_word(fmt_word);
          `REG_ADDR:    dat_o <= {17'h0, eff_addr};
          `REG_STORE:   dat_o <= pad_word(merged_word);
          default: begin
            if (adr_i[`ADDR_W-1])
              dat_o <= {17'h0, index_value(adr_i[4:2])};
            else
              dat_o <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/core_store_model.sv */
// Purpose: core storage stand-in on the far side of the address port
// Assumes: word addressed, 15-bit address, 30-bit words
// Notes:   contents follow the address, so every word differs
`timescale 1ns/1ps
`default_nettype none
module core_store_model (
  input  wire logic [14:0] addr_i,
  output logic      [29:0] word_o
);
  // halves differ so a swapped half fetch cannot pass
  assign word_o = {addr_i ^ 15'h5a5a, ~addr_i};
endmodule
`default_nettype wire

/* File: tb/operand_fmt_sva.sv */
// Purpose: port checks for the operand formatter
// Assumes: ack one cycle after a taken request
// Notes:   derived outputs move only after register writes
`timescale 1ns/1ps
`default_nettype none
module operand_fmt_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic [29:0] result_o,
  input wire logic [29:0] store_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  // four cycles cover the register write plus the derived update
  sequence s_quiet; (!(cyc_i && stb_i && we_i))[*4]; endsequence
  property p_ack_next; s_take |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ack_cause; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
  property p_idx0; ack_o && !we_i && adr_i == 6'h20 |-> dat_o == 32'h0; endproperty
  // the read-only registers and the ports are launched from one value
  property p_addr_w; ack_o && !we_i && adr_i == 6'h18 |-> dat_o == {17'h0, mem_addr_o}; endproperty
  property p_res_w; ack_o && !we_i && adr_i == 6'h14 |-> dat_o == {2'h0, result_o}; endproperty
  property p_quiet;
    s_quiet |=> $stable(result_o) && $stable(mem_addr_o) && $stable(store_word_o);
  endproperty
  property p_reset;
    $fell(rst_i) |-> !ack_o && result_o == 30'h0 && store_word_o == 30'h0 && mem_addr_o == 15'h0;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_idx0: assert property (p_idx0) else $error("index zero not zero");
  a_addr_w: assert property (p_addr_w) else $error("address read differs from port");
  a_res_w: assert property (p_res_w) else $error("result read differs from port");
  a_quiet: assert property (p_quiet) else $error("outputs moved unasked");
  a_reset: assert property (p_reset) else $error("outputs not clear");
endmodule
bind operand_half_word_formatter operand_fmt_sva chk_u (.*);
`default_nettype wire

/* File: tb/operand_half_word_formatter_bench.sv */
// Purpose: self-checking bench for the operand formatter
// Assumes: classic Wishbone single cycles, ack after one clock
// Notes:   expected formatted results come from the model function below; addresses and stores are worked inline
`timescale 1ns/1ps
`default_nettype none
module operand_half_word_formatter_bench;
  logic clk_i=0, rst_i=1, cyc_i=0, stb_i=0, we_i=0;
  logic [5:0] adr_i=0, a;
  logic [3:0] sel_i=0;
  logic [31:0] dat_i=0, rd;
  wire [31:0] dat_o;
  wire ack_o;
  wire [14:0] mem_addr_o;
  wire [29:0] result_o, store_word_o, core_word;
  integer bad_count=0, comparisons=0, seed=32'h10bc, m, n, w, x, b, e;
  always #25 clk_i = ~clk_i;
  operand_half_word_formatter dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .mem_addr_o(mem_addr_o), .result_o(result_o),
    .store_word_o(store_word_o));
  core_store_model store_u (.addr_i(mem_addr_o), .word_o(core_word));
  //////////////////////////////////////////////////////////////////////
  task finish_test;
    begin
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task bus(input logic wr, input logic [5:0] ad, input logic [31:0] d, input logic [3:0] s);
    begin
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= wr;
      adr_i <= ad;
      dat_i <= d;
      sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
    end
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk(input logic [5:0] ad, input logic [31:0] exp);
    begin
      bus(0, ad, 0, 4'hf);
      cmp(rd, exp);
    end
  endtask
  function [31:0] fmt(input logic [2:0] md, input logic [29:0] v);
    case (md)
      3'h0: fmt = v & 32'h7fff;
      3'h1: fmt = v >> 15;
      3'h3: fmt = (v & 32'h7fff) | (v[14] ? 32'h3fff8000 : 0);
      3'h4: fmt = (v >> 15) | (v[29] ? 32'h3fff8000 : 0);
      default: fmt = v;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count = bad_count + 1;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    // each mode twice: sign bits clear, then set
    for (m = 0; m < 14; m = m + 1) begin
      w = (m & 1) ? ($random(seed) | 32'h20004000) : ($random(seed) & 32'h1fffbfff);
      bus(1, 6'h10, w, 4'hf);
      bus(1, 6'h04, w, 4'hf);
      bus(1, 6'h00, (m >> 1) | ((m >> 1) > 4 ? 32'h30 : 0), 4'hf);
      e = (m >> 1) == 5 ? fmt(0, w) : (m >> 1) == 6 ? fmt(3, w) : fmt(m >> 1, w);
      chk(6'h14, e);
      cmp({2'h0, result_o}, e);
    end
    x = $random(seed) & 32'h3fffffff;
    bus(1, 6'h0c, x, 4'hf);
    bus(1, 6'h00, 32'h10, 4'hf);
    chk(6'h14, x);
    for (n = 0; n < 8; n = n + 1) begin
      x = $random(seed) & 32'h7fff;
      b = $random(seed) & 32'h7fff;
      e = $random(seed) & 32'h7fff;
      w = $random(seed) & 32'h3fffffff;
      a = 6'h20 + {n[2:0], 2'b0};
      bus(1, a, x, 4'hf);
      bus(1, 6'h08, b, 4'hf);
      bus(1, 6'h04, w, 4'hf);
      bus(1, 6'h00, (e << 16) | (n << 8), 4'hf);
      chk(6'h18, (b + e + (n ? x : 0)) & 32'h7fff);
      cmp({17'h0, mem_addr_o}, (b + e + (n ? x : 0)) & 32'h7fff);
      chk(a, n ? x : 0);
      chk(6'h04, (w & 32'h3fff8000) | ((w + (n ? x : 0)) & 32'h7fff));
    end
    // index register seven as the operand itself, plain then sign filled
    bus(1, 6'h00, 32'h720, 4'hf);
    chk(6'h14, x);
    bus(1, 6'h00, 32'h723, 4'hf);
    chk(6'h14, fmt(3, x));
    bus(1, 6'h00, 32'h4700, 4'hf);
    repeat (3) @(posedge clk_i);
    cmp({17'h0, mem_addr_o}, x);
    w = core_word;
    bus(1, 6'h10, w, 4'hf);
    chk(6'h14, fmt(0, w));
    for (m = 0; m < 3; m = m + 1) begin
      x = $random(seed) & 32'h3fffffff;
      w = $random(seed) & 32'h3fffffff;
      bus(1, 6'h0c, x, 4'hf);
      bus(1, 6'h10, w, 4'hf);
      bus(1, 6'h00, m << 12, 4'hf);
      e = m == 0 ? (w & 32'h3fff8000) | (x & 32'h7fff) :
          m == 1 ? ((x & 32'h7fff) << 15) | (w & 32'h7fff) : x;
      chk(6'h1c, e);
      cmp({2'h0, store_word_o}, e);
    end
    // spare codes: mode 7 reads whole, store mode 3 stores whole
    bus(1, 6'h00, 32'h3007, 4'hf);
    chk(6'h14, w);
    chk(6'h1c, x);
    bus(1, 6'h0c, ~x, 4'h3);
    chk(6'h0c, x);
    // reset in mid-run clears registers and outputs
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    chk(6'h0c, 0);
    cmp({2'h0, result_o}, 0);
    finish_test;
  end
endmodule
`default_nettype wire
